// file: swd_ctrl.sv
// Added by the designer: the strobed register port.
`default_nettype none
module swd_ctrl
  import swd_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = SWD_TIMEOUT_CYCLES,
  parameter int POR_CYCLES     = SWD_POR_CYCLES
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_op_exec,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [5:0]  i_irq_request,
  input  wire logic [5:0]  i_irq_mask,
  input  wire logic        i_irq_global_en,
  input  wire logic        i_stop_recovery_pin,
  input  wire logic        i_rc_osc,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_write,
  input  wire logic        i_reg_read,
  output logic [7:0]       o_reg_rdata,
  output logic             o_cpu_clk_en,
  output logic             o_osc_en,
  output logic             o_periph_clk_en,
  output logic             o_sys_reset,
  output logic [15:0]      o_reset_vector,
  output logic             o_halt_wake,
  output logic             o_flag_load,
  output logic             o_flag_z,
  output logic             o_flag_s,
  output logic             o_flag_v,
  output logic [7:0]       o_port2_pin_mode,
  output logic             o_sclk_div_bypass,
  output logic             o_auto_latch_dis
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  localparam int TO_W  = $clog2(TIMEOUT_CYCLES + 1);
  localparam int RST_W = $clog2(POR_CYCLES + SWD_RST_EXTRA_XTAL + 1);
  localparam logic [TO_W-1:0]  TO_LAST  = TO_W'(TIMEOUT_CYCLES - 1);
  localparam logic [RST_W-1:0] RST_LAST = RST_W'(POR_CYCLES + SWD_RST_EXTRA_XTAL - 1);

  swd_state_t       state_reg;
  swd_state_t       state_next;
  logic [3:0]       option_reg;
  logic [7:0]       port2_mode_reg;
  logic             wdt_en_reg;
  logic             run_halt_reg;
  logic [TO_W-1:0]  wdt_cnt_reg;
  logic [RST_W-1:0] rst_cnt_reg;
  logic             pin_recov_reg;
  logic             pin_s1_reg;
  logic             pin_s2_reg;
  logic             rc_s1_reg;
  logic             rc_s2_reg;
  logic             rc_prev_reg;
  logic             sclk_div_reg;
  logic             perm;
  logic             sclk_src;
  logic             wdt_active;
  logic             sclk_tick;
  logic             rc_tick;
  logic             src_tick;
  logic             mode_ok;
  logic             wdt_tick;
  logic             wdt_expire;
  logic             wake_req;
  logic             pin_low;
  logic             op_wdt;
  logic             op_run_halt;

  function automatic logic is_op(input logic v, input logic [7:0] code,
                                 input logic [7:0] want);
    is_op = v && (code == want);
  endfunction : is_op

  assign perm     = option_reg[SWD_OPT_PERM_WDT];
  assign sclk_src = option_reg[SWD_OPT_SCLK_SRC];
  assign op_wdt   = is_op(i_op_exec, i_opcode, SWD_OP_WDT) && (state_reg == SWD_RUN);
  assign op_run_halt = is_op(i_op_exec, i_opcode, SWD_OP_RUN_HALT) && (state_reg == SWD_RUN);
  assign wdt_active = wdt_en_reg || (perm && !sclk_src);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_reg  <= 1'b1;
      pin_s2_reg  <= 1'b1;
      rc_s1_reg   <= 1'b0;
      rc_s2_reg   <= 1'b0;
      rc_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg  <= i_stop_recovery_pin;
      pin_s2_reg  <= pin_s1_reg;
      rc_s1_reg   <= i_rc_osc;
      rc_s2_reg   <= rc_s1_reg;
      rc_prev_reg <= rc_s2_reg;
    end
  end

  assign pin_low = !pin_s2_reg;
  assign rc_tick = rc_s2_reg && !rc_prev_reg;

  // ------------------------------------------------------------
  // system clock divider
  // ------------------------------------------------------------
  // the divider is frozen in stop, so system-clocked logic cannot advance there
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sclk_div_reg <= 1'b0;
    end else if (state_reg != SWD_STOP) begin
      sclk_div_reg <= !sclk_div_reg;
    end
  end

  assign sclk_tick = (state_reg != SWD_STOP) &&
                     (option_reg[SWD_OPT_LOW_NOISE] || sclk_div_reg);

  // ------------------------------------------------------------
  // sleep state machine
  // ------------------------------------------------------------
  assign wake_req = i_irq_global_en && ((i_irq_request & i_irq_mask) != 6'h00);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SWD_RUN: begin
        // the core is trusted to have flushed its pipeline with a nop first
        if (wdt_expire) begin
          state_next = SWD_RESET;
        end else if (is_op(i_op_exec, i_opcode, SWD_OP_STOP)) begin
          state_next = SWD_STOP;
        end else if (is_op(i_op_exec, i_opcode, SWD_OP_HALT)) begin
          state_next = SWD_HALT;
        end
      end
      SWD_HALT: begin
        if (wdt_expire) begin
          state_next = SWD_RESET;
        end else if (wake_req) begin
          state_next = SWD_RUN;
        end
      end
      SWD_STOP: begin
        if (wdt_expire || pin_low) begin
          state_next = SWD_RESET;
        end
      end
      SWD_RESET: begin
        if (rst_cnt_reg == RST_LAST) begin
          state_next = SWD_RUN;
        end
      end
      default: begin
        state_next = SWD_RESET;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= SWD_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // reset length counter: power-on delay plus the extra oscillator cycles
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt_reg <= '0;
    end else if (state_reg != SWD_RESET) begin
      rst_cnt_reg <= '0;
    end else if (rst_cnt_reg != RST_LAST) begin
      rst_cnt_reg <= rst_cnt_reg + 1'b1;
    end
  end

  // remembers whether the current reset came from the recovery pin
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pin_recov_reg <= 1'b0;
    end else if (state_reg == SWD_STOP && state_next == SWD_RESET) begin
      pin_recov_reg <= pin_low && !wdt_expire;
    end else if (state_reg == SWD_RUN) begin
      pin_recov_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  always_comb begin
    case (state_reg)
      SWD_RUN:  mode_ok = 1'b1;
      SWD_HALT: mode_ok = run_halt_reg || perm;
      SWD_STOP: mode_ok = perm && !sclk_src;
      default:  mode_ok = 1'b0;
    endcase
  end

  assign src_tick   = sclk_src ? sclk_tick : rc_tick;
  assign wdt_tick   = wdt_active && mode_ok && src_tick;
  assign wdt_expire = wdt_tick && (wdt_cnt_reg == TO_LAST);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wdt_en_reg <= 1'b0;
    end else if (state_reg == SWD_RESET) begin
      wdt_en_reg <= 1'b0;
    end else if (op_wdt) begin
      wdt_en_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      run_halt_reg <= 1'b0;
    end else if (state_reg == SWD_RESET) begin
      run_halt_reg <= 1'b0;
    end else if (op_run_halt && wdt_active) begin
      run_halt_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wdt_cnt_reg <= '0;
    end else if (state_reg == SWD_RESET || op_wdt || wdt_expire) begin
      wdt_cnt_reg <= '0;
    end else if (wdt_tick) begin
      wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_flag_load <= 1'b0;
      o_flag_z    <= 1'b0;
      o_flag_s    <= 1'b0;
      o_flag_v    <= 1'b0;
    end else begin
      o_flag_load <= op_wdt;
      if (op_wdt) begin
        o_flag_z <= 1'b1;
        o_flag_s <= 1'b0;
        o_flag_v <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      port2_mode_reg <= SWD_PORT2_MODE_RST;
    end else if (state_reg == SWD_RESET && !pin_recov_reg) begin
      port2_mode_reg <= SWD_PORT2_MODE_RST;
    end else if (i_reg_write && i_reg_addr == SWD_ADDR_PORT2_MODE) begin
      port2_mode_reg <= i_reg_wdata;
    end
  end

  // options are written through the register port; only a power-on reset restores their default
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      option_reg <= SWD_OPT_RST;
    end else if (i_reg_write && i_reg_addr == SWD_ADDR_OPTION) begin
      option_reg <= i_reg_wdata[3:0];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= SWD_RDATA_ZERO;
    end else if (!i_reg_read) begin
      o_reg_rdata <= SWD_RDATA_ZERO;
    end else begin
      case (i_reg_addr)
        SWD_ADDR_STATUS: o_reg_rdata <= {2'b00, pin_recov_reg,
                                         state_reg == SWD_RESET,
                                         state_reg == SWD_STOP,
                                         state_reg == SWD_HALT,
                                         run_halt_reg, wdt_active};
        SWD_ADDR_OPTION: o_reg_rdata <= {4'h0, option_reg};
        default:         o_reg_rdata <= SWD_RDATA_ZERO;
      endcase
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_cpu_clk_en      <= 1'b0;
      o_osc_en          <= 1'b1;
      o_periph_clk_en   <= 1'b0;
      o_sys_reset       <= 1'b1;
      o_reset_vector    <= SWD_POWER_ON_VECTOR;
      o_halt_wake       <= 1'b0;
      o_port2_pin_mode  <= SWD_PORT2_MODE_RST;
      o_sclk_div_bypass <= 1'b0;
      o_auto_latch_dis  <= 1'b0;
    end else begin
      o_cpu_clk_en      <= (state_next == SWD_RUN);
      o_osc_en          <= (state_next != SWD_STOP);
      o_periph_clk_en   <= (state_next == SWD_RUN) || (state_next == SWD_HALT);
      o_sys_reset       <= (state_next == SWD_RESET);
      o_reset_vector    <= pin_recov_reg ? SWD_STOP_RECOVERY_VECTOR
                                         : SWD_POWER_ON_VECTOR;
      // a pulse tells the core to keep its pc, so return lands past the halt
      o_halt_wake       <= (state_reg == SWD_HALT) && (state_next == SWD_RUN);
      o_port2_pin_mode  <= port2_mode_reg;
      o_sclk_div_bypass <= option_reg[SWD_OPT_LOW_NOISE];
      o_auto_latch_dis  <= option_reg[SWD_OPT_LATCH_DIS];
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_halt_masked_sleep: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_reg == SWD_HALT && !wdt_expire && !wake_req) |=> state_reg == SWD_HALT)
    else $error("halt left without an enabled interrupt");

  chk_halt_gates_cpu: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_reg == SWD_HALT && $past(state_reg) == SWD_HALT)
      |-> (!o_cpu_clk_en && o_osc_en && o_periph_clk_en))
    else $error("halt clock gating wrong");

  chk_stop_osc_off: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_reg == SWD_STOP && $past(state_reg) == SWD_STOP)
      |-> (!o_osc_en && !o_periph_clk_en && !o_cpu_clk_en))
    else $error("stop did not freeze clocks");

  chk_pin_releases_stop: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_reg == SWD_STOP && pin_low) |=> state_reg == SWD_RESET ##1 o_sys_reset)
    else $error("recovery pin did not release stop");

  chk_recov_vector: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(pin_recov_reg) |-> ##1 o_reset_vector == 16'h000c)
    else $error("wrong vector after stop recovery");

  chk_pin_keeps_mode: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_reg == SWD_RESET && pin_recov_reg && !i_reg_write)
      |=> $stable(port2_mode_reg))
    else $error("port mode lost on pin recovery");

  chk_wdt_first_enable: assert property (@(posedge i_clock) disable iff (i_rst)
    op_wdt |=> (wdt_en_reg && wdt_cnt_reg == '0))
    else $error("watchdog opcode did not enable or clear");

  chk_wdt_no_disable: assert property (@(posedge i_clock) disable iff (i_rst)
    (wdt_en_reg && state_reg != SWD_RESET) |=> wdt_en_reg)
    else $error("watchdog disabled outside reset");

  chk_expire_reset_len: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_reg == SWD_RESET && rst_cnt_reg != RST_LAST) |=> state_reg == SWD_RESET)
    else $error("reset shorter than power-on delay plus 18");

  chk_flags_on_wdt: assert property (@(posedge i_clock) disable iff (i_rst)
    op_wdt |=> (o_flag_load && o_flag_z && !o_flag_s && !o_flag_v))
    else $error("watchdog flags wrong");

  chk_halt_wdt_frozen: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_reg == SWD_HALT && !run_halt_reg && !perm) |=> $stable(wdt_cnt_reg))
    else $error("watchdog counted in halt");

  chk_sclk_stop_frozen: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_reg == SWD_STOP && (sclk_src || !perm)) |=> $stable(wdt_cnt_reg))
    else $error("watchdog counted in stop");

  chk_runhalt_no_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    (op_run_halt && !wdt_tick && state_reg == SWD_RUN) |=> $stable(wdt_cnt_reg))
    else $error("run-in-halt opcode touched counter");

  chk_runhalt_needs_enable: assert property (@(posedge i_clock) disable iff (i_rst)
    (op_run_halt && !wdt_active && !run_halt_reg) |=> !run_halt_reg)
    else $error("run-in-halt opcode acted while disabled");

  cov_halt_wake: cover property (@(posedge i_clock) disable iff (i_rst)
    state_reg == SWD_HALT ##1 o_halt_wake);
  cov_stop_pin: cover property (@(posedge i_clock) disable iff (i_rst)
    state_reg == SWD_STOP ##1 state_reg == SWD_RESET ##1 pin_recov_reg);
  cov_wdt_expire: cover property (@(posedge i_clock) disable iff (i_rst)
    wdt_expire);

endmodule : swd_ctrl
`default_nettype wire

// file: swd_pkg.sv
`default_nettype none
package swd_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] SWD_ADDR_PORT2_MODE = 8'hf6;
  localparam logic [7:0] SWD_ADDR_STATUS     = 8'he0;
  localparam logic [7:0] SWD_ADDR_OPTION     = 8'he1;

  localparam logic [7:0] SWD_PORT2_MODE_RST  = 8'hff;
  localparam logic [7:0] SWD_RDATA_ZERO      = 8'h00;

  // option register fields
  localparam int SWD_OPT_PERM_WDT   = 0;
  localparam int SWD_OPT_SCLK_SRC   = 1;
  localparam int SWD_OPT_LOW_NOISE  = 2;
  localparam int SWD_OPT_LATCH_DIS  = 3;
  localparam logic [3:0] SWD_OPT_RST = 4'h0;

  // status register fields
  localparam int SWD_ST_WDT_EN     = 0;
  localparam int SWD_ST_RUN_HALT   = 1;
  localparam int SWD_ST_HALT       = 2;
  localparam int SWD_ST_STOP       = 3;
  localparam int SWD_ST_IN_RESET   = 4;
  localparam int SWD_ST_PIN_RECOV  = 5;

  // ------------------------------------------------------------
  // opcodes and vectors
  // ------------------------------------------------------------
  localparam logic [7:0]  SWD_OP_WDT  = 8'h5f;
  localparam logic [7:0]  SWD_OP_RUN_HALT = 8'h4f;
  localparam logic [7:0]  SWD_OP_STOP = 8'h6f;
  localparam logic [7:0]  SWD_OP_HALT = 8'h7f;
  localparam logic [15:0] SWD_STOP_RECOVERY_VECTOR = 16'h000c;
  localparam logic [15:0] SWD_POWER_ON_VECTOR      = 16'h000c;

  // ------------------------------------------------------------
  // timing: watchdog timeout in ticks of the selected watchdog source, reset lengths in i_clock cycles
  // ------------------------------------------------------------
  localparam int SWD_TIMEOUT_CYCLES = 130416;
  localparam int SWD_POR_CYCLES     = 16362;
  localparam int SWD_RST_EXTRA_XTAL = 18;

  typedef enum logic [1:0] {
    SWD_RUN   = 2'b00,
    SWD_HALT  = 2'b01,
    SWD_STOP  = 2'b10,
    SWD_RESET = 2'b11
  } swd_state_t;

endpackage : swd_pkg
`default_nettype wire

// file: swd_cpu_model.sv
`default_nettype none
module swd_cpu_model (
  input  wire logic       i_clock,
  output logic            o_op_exec,
  output logic [7:0]      o_opcode
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_op_exec = 1'b0;
    o_opcode  = 8'h00;
  end
  // sleep opcodes always get a nop first so the core never parks mid-instruction
  task automatic exec(input logic [7:0] op);
    if (op == 8'h6f || op == 8'h7f) begin
      @(posedge i_clock);
      o_op_exec <= 1'b1;
      o_opcode  <= 8'hff;
    end
    @(posedge i_clock);
    o_op_exec <= 1'b1;
    o_opcode  <= op;
    @(posedge i_clock);
    o_op_exec <= 1'b0;
    o_opcode  <= ~op; // a released bus does not keep the last opcode
  endtask : exec
endmodule : swd_cpu_model
`default_nettype wire

// file: test_swd_ctrl.sv
`default_nettype none
module test_swd_ctrl
  import swd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR = 8;
  logic clk = 1'b0, rc = 1'b0;
  logic rst, gen, pin, wr, rd, rd_d, exec, cpu_en, osc_en, per_en;
  logic sys_rst, wake, fload, fz, fs, fv, bypass, latch;
  logic [5:0] irq_req, mask;
  logic [7:0] addr, wdata, rdata, pmode, op, d;
  logic [15:0] vec;
  logic [7:0] q[$];
  int mismatches, checks_done, rises, n, seed;
  // ----
  // design and core
  // ----
  swd_ctrl #(.TIMEOUT_CYCLES(40), .POR_CYCLES(POR)) i_swd_ctrl (
    .i_clock(clk), .i_rst(rst), .i_op_exec(exec), .i_opcode(op),
    .i_irq_request(irq_req), .i_irq_mask(mask), .i_irq_global_en(gen),
    .i_stop_recovery_pin(pin), .i_rc_osc(rc), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd),
    .o_reg_rdata(rdata), .o_cpu_clk_en(cpu_en), .o_osc_en(osc_en),
    .o_periph_clk_en(per_en), .o_sys_reset(sys_rst), .o_reset_vector(vec),
    .o_halt_wake(wake), .o_flag_load(fload), .o_flag_z(fz), .o_flag_s(fs),
    .o_flag_v(fv), .o_port2_pin_mode(pmode), .o_sclk_div_bypass(bypass),
    .o_auto_latch_dis(latch));
  swd_cpu_model i_swd_cpu_model (.i_clock(clk), .o_op_exec(exec), .o_opcode(op));
  always #20 clk = ~clk;
  always #65 rc = ~rc; // rc oscillator, unrelated in phase
  always @(posedge sys_rst) rises++;
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) begin
      chk("rdata", rdata, q.pop_front());
    end
  end
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] v);
    q.push_back(v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
  endtask : rd_reg
  function automatic logic pick(input int w);
    case (w)
      0: return sys_rst;
      1: return wake;
      default: return ~sys_rst;
    endcase
  endfunction : pick
  task automatic wait_on(input int w, input int lim);
    n = 0;
    while (pick(w) !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        mismatches++;
        $display("CHECK FAILED wait %0d expected 1 seen 0", w);
        complete_run();
      end
    end
  endtask : wait_on
  task automatic boot();
    wait_on(2, 300);
    repeat (2) @(posedge clk);
    #1;
  endtask : boot
  // ----
  // sequence
  // ----
  initial begin
    {rst, gen, pin, wr, rd} = 5'h1c;
    {irq_req, mask, addr, wdata} = '0;
    {mismatches, checks_done, rises} = '0;
    seed = 32'h04a7;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    boot();
    rises = 0; // the power-on reset edge is not a watchdog reset
    rd_reg(SWD_ADDR_STATUS, 8'h00);
    rd_reg(SWD_ADDR_PORT2_MODE, 8'h00);
    rd_reg(8'h33, 8'h00);
    wr_reg(SWD_ADDR_OPTION, 8'h0c);
    @(posedge clk);
    #1 chk("bypass", bypass, 1'b1);
    chk("latch", latch, 1'b1);
    rd_reg(SWD_ADDR_OPTION, 8'h0c);
    wr_reg(SWD_ADDR_OPTION, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr_reg(SWD_ADDR_PORT2_MODE, d);
      @(posedge clk);
      #1 chk("port2 mode", pmode, d);
    end
    $display("test done: registers");
    i_swd_cpu_model.exec(SWD_OP_RUN_HALT);
    rd_reg(SWD_ADDR_STATUS, 8'h00);
    i_swd_cpu_model.exec(SWD_OP_WDT);
    #1 chk("flags", {fload, fz, fs, fv}, 4'hc);
    rd_reg(SWD_ADDR_STATUS, 8'h01);
    repeat (4) begin
      repeat (60) @(posedge clk);
      i_swd_cpu_model.exec(SWD_OP_WDT);
    end
    chk("refresh", 16'(rises), 16'h0);
    i_swd_cpu_model.exec(SWD_OP_HALT);
    #1 chk("halt en", {cpu_en, osc_en, per_en}, 3'h3);
    irq_req <= 6'h3f;
    repeat (300) @(posedge clk);
    #1 chk("masked", cpu_en, 1'b0);
    chk("halt wdt", 16'(rises), 16'h0);
    mask <= 6'h01;
    wait_on(1, 20);
    chk("wake", cpu_en, 1'b1);
    irq_req <= 6'h00;
    mask    <= 6'h00;
    $display("test done: halt");
    i_swd_cpu_model.exec(SWD_OP_RUN_HALT);
    rd_reg(SWD_ADDR_STATUS, 8'h03);
    i_swd_cpu_model.exec(SWD_OP_HALT);
    wait_on(0, 300);
    wait_on(2, 300);
    chk("reset len", 16'(n), 16'(POR + 18));
    boot();
    rd_reg(SWD_ADDR_STATUS, 8'h00);
    $display("test done: watchdog");
    wr_reg(SWD_ADDR_PORT2_MODE, 8'h80);
    i_swd_cpu_model.exec(SWD_OP_WDT);
    i_swd_cpu_model.exec(SWD_OP_STOP);
    #1 chk("stop en", {osc_en, per_en}, 2'h0);
    n = rises;
    repeat (300) @(posedge clk);
    chk("stop wdt", 16'(rises - n), 16'h0);
    pin <= 1'b0;
    wait_on(0, 10);
    chk("vector", vec, SWD_STOP_RECOVERY_VECTOR);
    // the recovery mark only shows while the internal reset lasts
    rd_reg(SWD_ADDR_STATUS, 8'h30);
    pin <= 1'b1;
    boot();
    chk("mode kept", pmode, 8'h80);
    rd_reg(SWD_ADDR_STATUS, 8'h00);
    $display("test done: stop");
    wr_reg(SWD_ADDR_OPTION, 8'h03);
    i_swd_cpu_model.exec(SWD_OP_WDT);
    wait_on(0, 90);
    boot();
    i_swd_cpu_model.exec(SWD_OP_WDT);
    i_swd_cpu_model.exec(SWD_OP_STOP);
    n = rises;
    repeat (300) @(posedge clk);
    chk("sclk stop", 16'(rises - n), 16'h0);
    pin <= 1'b0;
    wait_on(0, 10);
    pin <= 1'b1;
    boot();
    $display("test done: system clock");
    wr_reg(SWD_ADDR_OPTION, 8'h01);
    i_swd_cpu_model.exec(SWD_OP_STOP);
    wait_on(0, 300);
    $display("test done: permanent");
    complete_run();
  end
endmodule : test_swd_ctrl
`default_nettype wire
